// ---- design/flk_pkg.sv ----
// flk_pkg: shared constants, types and register map of the flash lock and security block
package flk_pkg;

  // ------------------------------------------------------------
  // flash geometry
  // ------------------------------------------------------------
  localparam int FL_AW = 19;
  localparam int LOCK_N = 16;
  localparam int REGION_LSB = 15;
  localparam int REGION_PAGES = 128;
  localparam int NVB_N = 4;
  localparam int NVB_SEC = 0;
  localparam int NVB_IDX_W = 4;

  // ------------------------------------------------------------
  // erase pin timing, counted in slow clock ticks
  // ------------------------------------------------------------
  localparam int SCLK_HZ = 32768;
  localparam int ERASE_IGNORE_MS = 100;
  localparam int ERASE_ACCEPT_MS = 220;
  localparam int ERASE_IGNORE_TICKS = (ERASE_IGNORE_MS * SCLK_HZ) / 1000;
  localparam int ERASE_ACCEPT_TICKS = (ERASE_ACCEPT_MS * SCLK_HZ + 999) / 1000;
  localparam int ERASE_CNT_W = 13;

  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam int WB_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_UID0 = 8'h18;
  localparam logic [7:0] REG_UID1 = 8'h1C;
  localparam logic [7:0] REG_UID2 = 8'h20;
  localparam logic [7:0] REG_UID3 = 8'h24;
  localparam logic [7:0] REG_CALIB = 8'h28;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_SEC = 1;
  localparam int ST_NVB_LSB = 4;
  localparam int ST_LOCK_LSB = 16;
  localparam int IRQ_N = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LOCK_ERR = 1;
  localparam int IRQ_CMD_ERR = 2;
  localparam int IRQ_WIPED = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PROG = 4'h1,
    OP_ERASE_PAGE = 4'h2,
    OP_SET_LOCK = 4'h3,
    OP_CLR_LOCK = 4'h4,
    OP_SET_NVB = 4'h5,
    OP_CLR_NVB = 4'h6,
    OP_CHIP_ERASE = 4'h7
  } flk_op_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_AW-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } flk_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } flk_wb_rsp_t;

  typedef struct packed {
    logic req;
    flk_op_t op;
    logic [FL_AW-1:0] addr;
  } flk_fl_req_t;

  typedef struct packed {
    logic [LOCK_N-1:0] lock;
    logic [NVB_N-1:0] gpnv;
  } flk_nv_t;

endpackage

// ---- design/flk_sync2.sv ----
// flk_sync2: two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module flk_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } flk_sync_st_t;

  flk_sync_st_t st_q;
  flk_sync_st_t st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// ---- design/flk_erase_filter.sv ----
// flk_erase_filter: debounces the erase pin by counting slow clock ticks while it is high
`timescale 1ns/1ps
module flk_erase_filter
  import flk_pkg::*;
#(
  parameter int ACCEPT_TICKS = ERASE_ACCEPT_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // synchronised inputs
  input wire logic pin_s,
  input wire logic sclk_s,
  // one-cycle request to wipe
  output logic erase_req
);
  typedef struct packed {
    logic sclk_prev;
    logic [ERASE_CNT_W-1:0] cnt;
    logic fired;
    logic req;
  } flk_flt_st_t;

  flk_flt_st_t st_q;
  flk_flt_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.sclk_prev = sclk_s;
    st_d.req = 1'b0;
    if (!pin_s) begin
      // short pulses never reach the threshold and are dropped here
      st_d.cnt = '0;
      st_d.fired = 1'b0;
    end else if (sclk_s && !st_q.sclk_prev && !st_q.fired) begin
      st_d.cnt = st_q.cnt + 1'b1;
      if (st_d.cnt >= ERASE_CNT_W'(ACCEPT_TICKS)) begin
        // one request per high level, however long it is held
        st_d.req = 1'b1;
        st_d.fired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign erase_req = st_q.req;
endmodule

// ---- design/flk_top.sv ----
// flk_top: flash lock bits, security bit, erase pin handling and wishbone register file
// ------------------------------------------------------------
// How it works
// - sixteen lock bits, each guards 32 kbyte
// - locked program or erase aborts, raises interrupt
// - set-lock and clear-lock commands change lock bits
// - accepted erase pin clears all lock bits
// - security bit shuts debug and fast programming ports
// - only set-nv-bit-0 command sets security; no clear
// - security clears only after erase-pin full flash erase
// - calibration bits read-only, erase pin leaves them
// - 128-bit unique id read-only, never erased
// - erase pin debounced: ignore short, accept long
// - erase pin wipes flash and nv bits
// ------------------------------------------------------------
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module flk_top
  import flk_pkg::*;
#(
  parameter int ACCEPT_TICKS = ERASE_ACCEPT_TICKS,
  parameter logic [127:0] UID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
  parameter logic [31:0] CALIB = 32'h0000_00A5
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire flk_pkg::flk_wb_req_t wb_req,
  output flk_pkg::flk_wb_rsp_t wb_rsp,
  // pins from outside
  input wire logic erase_pin,
  input wire logic sclk,
  // non-volatile store: contents at power-up and the image to keep
  input wire flk_pkg::flk_nv_t nv_init,
  output flk_pkg::flk_nv_t nv_image,
  // flash array command port
  output flk_pkg::flk_fl_req_t fl_req,
  input wire logic fl_done,
  // access gates for the debug probe and the fast programming port
  output logic debug_probe_port_en,
  output logic fast_programming_port_en,
  // interrupt
  output logic irq
);
  import flk_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_LOAD = 4'h1,
    S_IDLE = 4'h2,
    S_FLASH = 4'h4,
    S_WIPE = 4'h8
  } flk_fsm_t;

  typedef struct packed {
    flk_fsm_t fsm;
    logic ack;
    logic [31:0] rdat;
    logic [FL_AW-1:0] addr;
    logic [LOCK_N-1:0] lock;
    logic [NVB_N-1:0] gpnv;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_en;
    logic irq;
    logic fl_req;
    flk_op_t fl_op;
    logic [FL_AW-1:0] fl_addr;
    logic erase_pend;
    logic dbg_en;
    logic ffp_en;
  } flk_st_t;

  flk_st_t st_q;
  flk_st_t st_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] region_of(input logic [FL_AW-1:0] a);
    region_of = a[FL_AW-1:REGION_LSB];
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmask = (old & ~m) | (nw & m);
  endfunction

  // shut during the load cycle and whenever security is set
  function automatic logic port_open(input flk_fsm_t f, input logic [NVB_N-1:0] nv);
    port_open = !f[0] && !nv[NVB_SEC];
  endfunction

  function automatic logic nvb_valid(input logic [NVB_IDX_W-1:0] idx);
    nvb_valid = idx < NVB_IDX_W'(NVB_N);
  endfunction

  function automatic logic [LOCK_N-1:0] lock_write(input logic [LOCK_N-1:0] l,
                                                   input logic [3:0] r, input logic v);
    lock_write = l;
    lock_write[r] = v;
  endfunction

  function automatic logic [31:0] status_word(input logic busy, input logic [NVB_N-1:0] nv,
                                              input logic [LOCK_N-1:0] l);
    status_word = '0;
    status_word[ST_BUSY] = busy;
    status_word[ST_SEC] = nv[NVB_SEC];
    status_word[ST_NVB_LSB +: NVB_N] = nv;
    status_word[ST_LOCK_LSB +: LOCK_N] = l;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and erase pin filter
  // ------------------------------------------------------------
  logic [1:0] pins_s;
  logic erase_req;

  flk_sync2 #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({erase_pin, sclk}),
    .q(pins_s)
  );

  flk_erase_filter #(
    .ACCEPT_TICKS(ACCEPT_TICKS)
  ) u_filter (
    .clk(clk),
    .arst_n(arst_n),
    .pin_s(pins_s[1]),
    .sclk_s(pins_s[0]),
    .erase_req(erase_req)
  );

  // ------------------------------------------------------------
  // bus and command decode
  // ------------------------------------------------------------
  logic bus_hit;
  logic bus_wr;
  logic [31:0] wdat;
  flk_op_t cmd_op;
  logic [NVB_IDX_W-1:0] cmd_arg;
  logic cmd_wr;
  logic [3:0] cmd_region;
  logic cmd_locked;

  always_comb begin
    // ack gates the next take, so a master that keeps stb up gets one pulse per access
    bus_hit = wb_req.cyc && wb_req.stb && !st_q.ack;
    bus_wr = bus_hit && wb_req.we;
    wdat = wb_req.dat;
    cmd_op = flk_op_t'(wdat[CMD_OP_LSB +: 4]);
    cmd_arg = wdat[CMD_ARG_LSB +: NVB_IDX_W];
    cmd_wr = bus_wr && wb_req.adr == REG_CMD;
    // the region follows the address register as it stands when the command lands
    cmd_region = region_of(st_q.addr);
    cmd_locked = st_q.lock[cmd_region];
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_clr;
  logic [31:0] status;
  logic gate_open;

  always_comb begin
    st_d = st_q;
    irq_set = '0;
    irq_clr = '0;
    st_d.fl_req = 1'b0;
    st_d.ack = bus_hit;

    // erase requests wait for the command in flight; set wins over take
    if (erase_req) begin
      st_d.erase_pend = 1'b1;
    end

    status = status_word(!st_q.fsm[1], st_q.gpnv, st_q.lock);

    // register reads; unmapped and write-only offsets read as zero
    st_d.rdat = '0;
    if (bus_hit && !wb_req.we) begin
      unique case (wb_req.adr)
        REG_ADDR: st_d.rdat = 32'(st_q.addr);
        REG_STATUS: st_d.rdat = status;
        REG_IRQ_STAT: st_d.rdat = 32'(st_q.irq_stat);
        REG_IRQ_EN: st_d.rdat = 32'(st_q.irq_en);
        REG_UID0: st_d.rdat = UID[31:0];
        REG_UID1: st_d.rdat = UID[63:32];
        REG_UID2: st_d.rdat = UID[95:64];
        REG_UID3: st_d.rdat = UID[127:96];
        // identifier and trim are parameters, so neither a write nor a wipe reaches them
        REG_CALIB: st_d.rdat = CALIB;
        default: st_d.rdat = '0;
      endcase
    end

    // register writes that do not start commands
    if (bus_wr) begin
      unique case (wb_req.adr)
        REG_ADDR: st_d.addr = FL_AW'(wmask(32'(st_q.addr), wdat, wb_req.sel));
        REG_IRQ_CLR: irq_clr = wdat[IRQ_N-1:0];
        REG_IRQ_EN: st_d.irq_en = IRQ_N'(wmask(32'(st_q.irq_en), wdat, wb_req.sel));
        default: ;
      endcase
    end

    unique case (st_q.fsm)
      S_LOAD: begin
        // nv contents are taken once, after reset has been released
        // a command written in this cycle is acked but dropped; software polls busy first
        st_d.lock = nv_init.lock;
        st_d.gpnv = nv_init.gpnv;
        st_d.fsm = S_IDLE;
      end
      S_IDLE: begin
        if (st_q.erase_pend) begin
          st_d.erase_pend = erase_req;
          st_d.fl_req = 1'b1;
          st_d.fl_op = OP_CHIP_ERASE;
          st_d.fl_addr = '0;
          st_d.lock = '0;
          st_d.fsm = S_WIPE;
          // a command landing in the same cycle loses to the wipe and is reported
          if (cmd_wr) begin
            irq_set[IRQ_CMD_ERR] = 1'b1;
          end
        end else if (cmd_wr && wb_req.sel[0]) begin
          unique case (cmd_op)
            OP_PROG, OP_ERASE_PAGE: begin
              if (cmd_locked) begin
                irq_set[IRQ_LOCK_ERR] = 1'b1;
              end else begin
                st_d.fl_req = 1'b1;
                st_d.fl_op = cmd_op;
                st_d.fl_addr = st_q.addr;
                st_d.fsm = S_FLASH;
              end
            end
            OP_SET_LOCK: begin
              st_d.lock = lock_write(st_q.lock, cmd_region, 1'b1);
              irq_set[IRQ_DONE] = 1'b1;
            end
            OP_CLR_LOCK: begin
              st_d.lock = lock_write(st_q.lock, cmd_region, 1'b0);
              irq_set[IRQ_DONE] = 1'b1;
            end
            OP_SET_NVB: begin
              if (nvb_valid(cmd_arg)) begin
                st_d.gpnv[cmd_arg[1:0]] = 1'b1;
                irq_set[IRQ_DONE] = 1'b1;
              end else begin
                irq_set[IRQ_CMD_ERR] = 1'b1;
              end
            end
            OP_CLR_NVB: begin
              // the security bit is never cleared by software
              if (nvb_valid(cmd_arg) && cmd_arg != NVB_IDX_W'(NVB_SEC)) begin
                st_d.gpnv[cmd_arg[1:0]] = 1'b0;
                irq_set[IRQ_DONE] = 1'b1;
              end else begin
                irq_set[IRQ_CMD_ERR] = 1'b1;
              end
            end
            default: irq_set[IRQ_CMD_ERR] = 1'b1;
          endcase
        end
      end
      S_FLASH: begin
        // one op at a time; a second command is refused, not queued
        if (cmd_wr) begin
          irq_set[IRQ_CMD_ERR] = 1'b1;
        end
        if (fl_done) begin
          irq_set[IRQ_DONE] = 1'b1;
          st_d.fl_op = OP_NONE;
          st_d.fsm = S_IDLE;
        end
      end
      S_WIPE: begin
        // security holds until the whole array is erased
        if (cmd_wr) begin
          irq_set[IRQ_CMD_ERR] = 1'b1;
        end
        if (fl_done) begin
          st_d.gpnv = '0;
          st_d.lock = '0;
          irq_set[IRQ_WIPED] = 1'b1;
          st_d.fl_op = OP_NONE;
          st_d.fsm = S_IDLE;
        end
      end
      default: st_d.fsm = S_IDLE;
    endcase

    // sticky status: a new event wins over a clear in the same cycle
    st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
    st_d.irq = |(st_d.irq_stat & st_d.irq_en);
    // irq is registered, so it trails the event by one cycle

    // ports stay shut until the nv contents have been loaded
    gate_open = port_open(st_d.fsm, st_d.gpnv);
    st_d.dbg_en = gate_open;
    st_d.ffp_en = gate_open;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.fsm <= S_LOAD;
      st_q.fl_op <= OP_NONE;
      st_q.irq_en <= IRQ_EN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a flop of the state struct, so nothing combinational leaves the block
  assign wb_rsp.ack = st_q.ack;
  assign wb_rsp.dat = st_q.rdat;
  assign fl_req.req = st_q.fl_req;
  assign fl_req.op = st_q.fl_op;
  assign fl_req.addr = st_q.fl_addr;
  assign nv_image.lock = st_q.lock;
  assign nv_image.gpnv = st_q.gpnv;
  assign debug_probe_port_en = st_q.dbg_en;
  assign fast_programming_port_en = st_q.ffp_en;
  assign irq = st_q.irq;
endmodule

// ---- tb/flk_flash_model.sv ----
// flk_flash_model: flash array stand-in that answers each started op after a short or long wait
`timescale 1ns/1ps
module flk_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // command port
  input wire flk_pkg::flk_fl_req_t fl_req,
  input wire logic slow,
  output logic fl_done,
  // what was asked of the array, for the bench
  output logic [7:0] req_cnt,
  output flk_pkg::flk_op_t last_op,
  output logic [18:0] last_addr
);
  import flk_pkg::*;
  logic busy_q;
  logic [7:0] cnt_q;
  // ------------------------------------------------------------
  // op timing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      fl_done <= 1'b0;
      req_cnt <= 8'h00;
      last_op <= OP_NONE;
      last_addr <= '0;
    end else begin
      fl_done <= 1'b0;
      if (fl_req.req) begin
        // every op kind starts the same countdown: 12 cycles when slow is set, 1 otherwise
        busy_q <= 1'b1;
        cnt_q <= slow ? 8'h0C : 8'h01;
        req_cnt <= req_cnt + 8'h01;
        last_op <= fl_req.op;
        last_addr <= fl_req.addr;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          busy_q <= 1'b0;
          fl_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- tb/flk_props.sv ----
// flk_props: port-level checks of the flash lock and security block
`timescale 1ns/1ps
module flk_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus and pins
  input wire flk_pkg::flk_wb_req_t wb_req,
  input wire flk_pkg::flk_wb_rsp_t wb_rsp,
  input wire logic erase_pin,
  input wire logic sclk,
  // nv store and flash port
  input wire flk_pkg::flk_nv_t nv_init,
  input wire flk_pkg::flk_nv_t nv_image,
  input wire flk_pkg::flk_fl_req_t fl_req,
  input wire logic fl_done,
  // gates and interrupt
  input wire logic debug_probe_port_en,
  input wire logic fast_programming_port_en,
  input wire logic irq
);
  import flk_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  a_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  a_ack_next_edge: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("access not answered in the next cycle");
  a_rdata_idle_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data not zero outside ack");
  // ------------------------------------------------------------
  // flash port and protection
  // ------------------------------------------------------------
  a_req_single_pulse: assert property (fl_req.req |=> !fl_req.req)
    else $error("flash request longer than one cycle");
  a_op_addr_hold: assert property (fl_req.op != OP_NONE && !fl_done |=>
    $stable(fl_req.op) && $stable(fl_req.addr)) else $error("op or address moved mid-op");
  a_locked_no_req: assert property (fl_req.req && (fl_req.op == OP_PROG ||
    fl_req.op == OP_ERASE_PAGE) |-> !nv_image.lock[fl_req.addr[FL_AW-1:REGION_LSB]])
    else $error("program or erase started in a locked region");
  a_wipe_unlocks_all: assert property (fl_req.req && fl_req.op == OP_CHIP_ERASE |->
    nv_image.lock == '0) else $error("locks not cleared at wipe start");
  a_sec_clear_wipe: assert property ($fell(nv_image.gpnv[NVB_SEC]) |-> $past(fl_done) &&
    $past(fl_req.op) == OP_CHIP_ERASE) else $error("security cleared without a wipe");
  a_ports_shut_sec: assert property ($past(nv_image.gpnv[NVB_SEC]) &&
    nv_image.gpnv[NVB_SEC] |-> !debug_probe_port_en && !fast_programming_port_en)
    else $error("port open while secured");
  a_ports_follow_sec: assert property ($past(arst_n) |->
    debug_probe_port_en == !nv_image.gpnv[NVB_SEC] &&
    fast_programming_port_en == debug_probe_port_en)
    else $error("port gates disagree with security");
  // ------------------------------------------------------------
  // main scenarios
  // ------------------------------------------------------------
  c_prog: cover property (fl_req.req && fl_req.op == OP_PROG);
  c_wipe: cover property (fl_req.req && fl_req.op == OP_CHIP_ERASE);
  c_unsecure: cover property ($fell(nv_image.gpnv[NVB_SEC]));
  c_irq: cover property (irq);
endmodule
bind flk_top flk_props u_flk_props (.clk(clk), .arst_n(arst_n), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .erase_pin(erase_pin), .sclk(sclk), .nv_init(nv_init),
  .nv_image(nv_image), .fl_req(fl_req), .fl_done(fl_done),
  .debug_probe_port_en(debug_probe_port_en),
  .fast_programming_port_en(fast_programming_port_en), .irq(irq));

// ---- tb/flk_top_bench.sv ----
// flk_top_bench: self-checking bench of the flash lock and security block
`timescale 1ns/1ps
module flk_top_bench;
  import flk_pkg::*;
  localparam int TICKS = 8;
  // arbitrary identifier and trim values
  localparam logic [127:0] UID_V = 128'h5A5A_1234_0F0F_9876_C3C3_4321_F0F0_6789;
  localparam logic [31:0] CAL_V = 32'h0000_003C;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  flk_wb_req_t wb_req = '0;
  flk_wb_rsp_t wb_rsp;
  logic erase_pin = 1'b0;
  logic sclk = 1'b0;
  flk_nv_t nv_init = '{16'h0001, 4'h0};
  flk_nv_t nv_image;
  flk_fl_req_t fl_req;
  logic fl_done, dbg_en, ffp_en, irq;
  logic slow = 1'b0;
  logic [7:0] req_cnt, n;
  flk_op_t last_op;
  logic [18:0] last_addr;
  logic [31:0] q;
  int err_total = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int sdiv = 0;
  flk_top #(.ACCEPT_TICKS(TICKS), .UID(UID_V), .CALIB(CAL_V)) u_flk_top (.clk(clk),
    .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .erase_pin(erase_pin), .sclk(sclk),
    .nv_init(nv_init), .nv_image(nv_image), .fl_req(fl_req), .fl_done(fl_done),
    .debug_probe_port_en(dbg_en), .fast_programming_port_en(ffp_en), .irq(irq));
  flk_flash_model u_flk_flash_model (.clk(clk), .arst_n(arst_n), .fl_req(fl_req),
    .slow(slow), .fl_done(fl_done), .req_cnt(req_cnt), .last_op(last_op),
    .last_addr(last_addr));
  // ------------------------------------------------------------
  // clocks and timeout
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;
  // slow clock sped up to 20 clk per period so the shortened tick count stays brief
  always @(posedge clk) begin
    cyc_n++;
    if (sdiv == 9) begin
      sdiv = 0;
      sclk <= ~sclk;
    end else sdiv++;
    if (cyc_n == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do @(posedge clk); while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(name, q, exp);
  endtask
  task automatic cmd(input flk_op_t op, input logic [3:0] arg);
    wb(1'b1, REG_CMD, {20'h00000, arg, 4'h0, op});
    for (int i = 0; i < 30; i++) begin
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      if (q[ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic pulse(input int cycles);
    @(posedge clk);
    erase_pin <= 1'b1;
    repeat (cycles) @(posedge clk);
    erase_pin <= 1'b0;
  endtask
  task automatic id_fixed();
    for (int i = 0; i < 4; i++) rdc("uid", REG_UID0 + 8'(4 * i), UID_V[32 * i +: 32]);
    rdc("calib", REG_CALIB, CAL_V);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    id_fixed();
    wb(1'b1, REG_UID0, 32'hFFFF_FFFF);
    wb(1'b1, REG_CALIB, 32'hFFFF_FFFF);
    id_fixed();
    rdc("unmapped", 8'h3C, 32'h0000_0000);
    rdc("irq_en", REG_IRQ_EN, 32'h0000_0000);
    rdc("status", REG_STATUS, 32'h0001_0000);
    check("dbg_open", dbg_en, 1'b1);
    $display("t_regs done");
  endtask
  task automatic t_lock();
    wb(1'b1, REG_IRQ_EN, 32'h0000_0002);
    wb(1'b1, REG_ADDR, 32'h0001_8000);
    cmd(OP_SET_LOCK, 4'h0);
    check("locks", q[31:16], 16'h0009);
    n = req_cnt;
    cmd(OP_PROG, 4'h0);
    cmd(OP_ERASE_PAGE, 4'h0);
    check("no_req", req_cnt, n);
    check("irq_on", irq, 1'b1);
    rdc("lock_err", REG_IRQ_STAT, 32'h0000_0003);
    wb(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    check("irq_off", irq, 1'b0);
    slow <= 1'b1;
    wb(1'b1, REG_ADDR, 32'h0001_7FFC);
    cmd(OP_PROG, 4'h0);
    check("edge_req", req_cnt, n + 8'h01);
    check("edge_addr", last_addr, 19'h17FFC);
    wb(1'b1, REG_ADDR, 32'h0001_8000);
    cmd(OP_CLR_LOCK, 4'h0);
    check("unlock", q[31:16], 16'h0001);
    cmd(OP_ERASE_PAGE, 4'h0);
    check("erase_ok", last_op, OP_ERASE_PAGE);
    $display("t_lock done");
  endtask
  task automatic t_sec();
    cmd(OP_SET_NVB, 4'h0);
    check("sec_on", q[ST_SEC], 1'b1);
    check("dbg_shut", dbg_en, 1'b0);
    check("ffp_shut", ffp_en, 1'b0);
    cmd(OP_CLR_NVB, 4'h0);
    check("sec_kept", q[ST_SEC], 1'b1);
    rdc("cmd_err", REG_IRQ_STAT, 32'h0000_0005);
    $display("t_sec done");
  endtask
  task automatic t_pin();
    n = req_cnt;
    pulse(3 * 20);
    repeat (10) @(posedge clk);
    check("short_pin", req_cnt, n);
    // held well past the accept count, as the outside party must
    pulse((TICKS + 4) * 20);
    cmd(OP_NONE, 4'h0);
    check("wipe_op", last_op, OP_CHIP_ERASE);
    check("wiped", q, 32'h0000_0000);
    check("dbg_back", dbg_en, 1'b1);
    check("ffp_back", ffp_en, 1'b1);
    check("nv_image", nv_image, 32'h0000_0000);
    rdc("wipe_flag", REG_IRQ_STAT, 32'h0000_000D);
    id_fixed();
    $display("t_pin done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_lock();
    t_sec();
    t_pin();
    complete_run();
  end
endmodule
